// *** src/ldc_pkg.sv ***
// Shared constants for the LED dimming and soft-start control block
package ldc_pkg;
  localparam int DIM_W = 10;
  localparam logic [9:0] DIM_MAX = 10'h3FF;
  localparam logic [9:0] DIM_LOAD_CNT = 10'h3FE;
  localparam logic [9:0] DIM_HALF = 10'h200;
  localparam logic [7:0] RAMP_MAX = 8'hFF;
  localparam logic [7:0] RAMP_RST = 8'h00;
  localparam logic [9:0] DUTY_RST = 10'h000;
  localparam logic [2:0] TRIM_RST = 3'h0;
  localparam int TRIM_STEP_UV = 2500;
  localparam logic [15:0] TRIM_STEP_CODE = 16'h09C4;
  typedef enum logic [2:0] {
    LDC_SS_IDLE = 3'b001,
    LDC_SS_RAMP = 3'b010,
    LDC_SS_DONE = 3'b100
  } ldc_ss_t;
endpackage

// *** src/ldc_chan.sv ***
`timescale 1ns/1ns
// One channel: duty staging, dimming counter, soft-start ramp
module ldc_chan (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Timing enables
  input wire logic dimTick,
  input wire logic ssTick,
  input wire logic [9:0] phaseOffset,
  input wire logic counterSync,
  // Duty writes
  input wire logic [1:0] dutyHighIn,
  input wire logic dutyHighWr,
  input wire logic [7:0] dutyLowIn,
  input wire logic dutyLowWr,
  // Ramp control
  input wire logic channelOn,
  input wire logic dimActive,
  // Results
  output logic dimOut,
  output logic [9:0] dimCount,
  output logic [7:0] rampValue,
  output logic rampDone
);
  logic [1:0] highPart_reg;
  logic [9:0] pending_reg;
  logic [9:0] compare_reg;
  logic [9:0] count_reg;
  logic [9:0] count_next;
  logic dim_reg;
  logic [7:0] ramp_reg;
  ldc_pkg::ldc_ss_t ss_reg;
  ldc_pkg::ldc_ss_t ss_next;
  wire logic loadPoint = dimTick && (count_reg == ldc_pkg::DIM_LOAD_CNT);
  wire logic rampStep = ssTick && dimActive && (ss_reg == ldc_pkg::LDC_SS_RAMP);

  assign dimOut = dim_reg;
  assign dimCount = count_reg;
  assign rampValue = ramp_reg;
  assign rampDone = (ss_reg == ldc_pkg::LDC_SS_DONE);
  // Counter wraps naturally after 1023; resync applies phase offset
  assign count_next = counterSync ? phaseOffset : 10'(count_reg + 10'h001);

  // Duty staging: coherent only on low-part write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      highPart_reg <= 2'h0;
      pending_reg <= ldc_pkg::DUTY_RST;
    end else begin
      if (dutyHighWr) begin
        highPart_reg <= dutyHighIn;
      end
      if (dutyLowWr) begin
        pending_reg <= {dutyHighWr ? dutyHighIn : highPart_reg, dutyLowIn};
      end
    end
  end

  // Dimming counter; compare only changes at count 1022 to keep period intact
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 10'h000;
      compare_reg <= ldc_pkg::DUTY_RST;
      dim_reg <= 1'b0;
    end else begin
      if (dimTick || counterSync) begin
        count_reg <= count_next;
        dim_reg <= (count_next < compare_reg);
      end
      if (loadPoint) begin
        compare_reg <= pending_reg;
      end
    end
  end

  // Soft-start sequencing
  always_comb begin
    ss_next = ss_reg;
    case (ss_reg)
      ldc_pkg::LDC_SS_IDLE: begin
        if (channelOn && dimActive) begin
          ss_next = ldc_pkg::LDC_SS_RAMP;
        end
      end
      ldc_pkg::LDC_SS_RAMP: begin
        if (rampStep && ramp_reg == ldc_pkg::RAMP_MAX) begin
          ss_next = ldc_pkg::LDC_SS_DONE;
        end
      end
      ldc_pkg::LDC_SS_DONE: ss_next = ldc_pkg::LDC_SS_DONE;
      default: ss_next = ldc_pkg::LDC_SS_IDLE;
    endcase
    if (!channelOn) begin
      ss_next = ldc_pkg::LDC_SS_IDLE;
    end
  end

  // Ramp counter: frozen while dimming low, cleared when channel off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ss_reg <= ldc_pkg::LDC_SS_IDLE;
      ramp_reg <= ldc_pkg::RAMP_RST;
    end else begin
      ss_reg <= ss_next;
      if (!channelOn) begin
        ramp_reg <= ldc_pkg::RAMP_RST;
      end else if (rampStep && ramp_reg != ldc_pkg::RAMP_MAX) begin
        ramp_reg <= 8'(ramp_reg + 8'h01);
      end
    end
  end
endmodule

// *** src/led_dimming_softstart_ctrl.sv ***
`timescale 1ns/1ns
// Top: dimming source select, clock dividers, gate and series-FET drive
// Behaviour
// - Select bit picks pin or internal dimming
// - Pins ignored while internal dimming selected
// - Per-channel 10-bit dimming counter and duty
// - Duty transfers only on low-part write
// - Pending duty loads at count 1022
// - Divider from 3-bit field; period 1024
// - Phase bit 0 gives 180 degrees
// - Dim low: channel off, comp open, FET off
// - Rising dim re-enables; comp waits sense
// - Reset leaves external dimming selected
// - FET drive follows dim, gated by enable
// - 8-bit ramp counts 0 to 255
// - Ramp clock is switch clock divided
// - Ramp waits for active dimming high
// - Ramp freezes while dimming low
// - Dual phase shares channel-1 compensation
// - Dual phase uses channel-1 ramp only
// - Dual phase clocks from channel-1 divider
// - Dual phase: ch1 internal dimming drives ch2; ch2 faults ignored
// - 3-bit trim adds 2.5 mV steps
// - Gate-off bit turns channel off
// - External-to-internal switch may glitch a period
module led_dimming_softstart_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration bits
  input wire logic internalDimSelect,
  input wire logic dimPhaseSelect,
  input wire logic dualPhaseSelect,
  input wire logic [2:0] dimClockDivider,
  input wire logic [7:0] rampClockDivider1,
  input wire logic [7:0] rampClockDivider2,
  input wire logic [7:0] switchClockDivider1,
  input wire logic [7:0] switchClockDivider2,
  input wire logic [1:0] channelEnable,
  input wire logic [1:0] seriesFetDriveEnable,
  input wire logic [1:0] channelGateOff,
  input wire logic [2:0] phaseOffsetTrim1,
  input wire logic [2:0] phaseOffsetTrim2,
  // Duty writes, one strobe per register write
  input wire logic [1:0] dimDutyHighPart1,
  input wire logic dimDutyHighWr1,
  input wire logic [7:0] dimDutyLowPart1,
  input wire logic dimDutyLowWr1,
  input wire logic [1:0] dimDutyHighPart2,
  input wire logic dimDutyHighWr2,
  input wire logic [7:0] dimDutyLowPart2,
  input wire logic dimDutyLowWr2,
  // Pins and analog comparator results
  input wire logic [1:0] dimmingInputPin,
  input wire logic [1:0] senseAboveComp,
  input wire logic [1:0] ch2FaultEvents,
  // Outputs
  output logic [1:0] internalDimSignal,
  output logic [1:0] activeDim,
  output logic [1:0] switchGateEnable,
  output logic [1:0] seriesFetDrive,
  output logic [1:0] compensationConnect,
  output logic ch2ErrorAmpDisable,
  output logic compTie,
  output logic [1:0] channelSwitchClock,
  output logic [7:0] rampConverter1,
  output logic [7:0] rampConverter2,
  output logic [15:0] trimOffsetUv1,
  output logic [15:0] trimOffsetUv2,
  output logic ch2FaultsActive
);
  logic [7:0] dimDiv_reg;
  logic dimTick_reg;
  logic [7:0] sw1Cnt_reg;
  logic [7:0] sw2Cnt_reg;
  logic [1:0] swClk_reg;
  logic [7:0] ss1Cnt_reg;
  logic [7:0] ss2Cnt_reg;
  logic [1:0] ssTick_reg;
  logic [1:0] extDim_reg;
  logic [1:0] prevDim_reg;
  logic [1:0] compArm_reg;
  logic [1:0] intDim_reg;
  logic [1:0] activeDim_reg;
  logic [1:0] gate_reg;
  logic [1:0] fet_reg;
  logic [1:0] comp_reg;
  logic [1:0] swClkOut_reg;
  logic [7:0] ramp1_reg;
  logic [7:0] ramp2_reg;
  logic [15:0] trim1_reg;
  logic [15:0] trim2_reg;
  logic dual_reg;
  logic phase_reg;
  logic sync_reg;
  logic [1:0] chanDim;
  logic [1:0] chanRampDone;
  logic [9:0] cnt1;
  logic [9:0] cnt2;
  logic [7:0] ramp1;
  logic [7:0] ramp2;

  // Divide factor 2^field: field 1 gives divide by 2
  wire logic [7:0] dimDivLimit = 8'((8'h01 << dimClockDivider) - 8'h01);
  wire logic dimDivWrap = (dimDiv_reg >= dimDivLimit);
  // Switching dividers: dual phase uses channel-1 factor for both
  wire logic [7:0] sw2Limit = dualPhaseSelect ? switchClockDivider1 : switchClockDivider2;
  wire logic sw1Wrap = (sw1Cnt_reg >= switchClockDivider1);
  wire logic sw2Wrap = (sw2Cnt_reg >= sw2Limit);
  wire logic [1:0] swRise = {sw2Wrap, sw1Wrap};
  wire logic ss1Wrap = swRise[0] && (ss1Cnt_reg >= rampClockDivider1);
  wire logic ss2Wrap = swRise[1] && (ss2Cnt_reg >= rampClockDivider2);
  // Phase change or mode change restarts counter pair at the new offset
  wire logic cfgChange = (dimPhaseSelect != phase_reg) || (dualPhaseSelect != dual_reg);
  wire logic [9:0] ch2Offset = dimPhaseSelect ? 10'h000 : ldc_pkg::DIM_HALF;
  // Dimming source; channel 2 follows channel 1 in dual phase with internal dimming
  wire logic [1:0] intSel = {dualPhaseSelect ? chanDim[0] : chanDim[1], chanDim[0]};
  wire logic [1:0] srcDim = internalDimSelect ? intSel : extDim_reg;
  wire logic [1:0] chanOn = channelEnable & ~channelGateOff;
  wire logic [1:0] runDim = srcDim & chanOn;
  wire logic [1:0] dimRise = runDim & ~prevDim_reg;
  wire logic ch2Ramp = dualPhaseSelect ? chanRampDone[0] : chanRampDone[1];
  wire logic [7:0] ramp2Sel = dualPhaseSelect ? ramp1 : ramp2;

  // Dimming counter clock enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dimDiv_reg <= 8'h00;
      dimTick_reg <= 1'b0;
      phase_reg <= 1'b0;
      dual_reg <= 1'b0;
      sync_reg <= 1'b1;
    end else begin
      dimDiv_reg <= dimDivWrap ? 8'h00 : 8'(dimDiv_reg + 8'h01);
      dimTick_reg <= dimDivWrap;
      phase_reg <= dimPhaseSelect;
      dual_reg <= dualPhaseSelect;
      sync_reg <= cfgChange;
    end
  end

  // Switching and ramp clock dividers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw1Cnt_reg <= 8'h00;
      sw2Cnt_reg <= 8'h00;
      swClk_reg <= 2'b00;
      ss1Cnt_reg <= 8'h00;
      ss2Cnt_reg <= 8'h00;
      ssTick_reg <= 2'b00;
    end else begin
      sw1Cnt_reg <= sw1Wrap ? 8'h00 : 8'(sw1Cnt_reg + 8'h01);
      if (dualPhaseSelect && sw1Cnt_reg == {1'b0, switchClockDivider1[7:1]}) begin
        sw2Cnt_reg <= 8'h00;
      end else begin
        sw2Cnt_reg <= sw2Wrap ? 8'h00 : 8'(sw2Cnt_reg + 8'h01);
      end
      swClk_reg <= swRise;
      if (swRise[0]) begin
        ss1Cnt_reg <= ss1Wrap ? 8'h00 : 8'(ss1Cnt_reg + 8'h01);
      end
      if (swRise[1]) begin
        ss2Cnt_reg <= ss2Wrap ? 8'h00 : 8'(ss2Cnt_reg + 8'h01);
      end
      ssTick_reg <= {ss2Wrap, ss1Wrap};
    end
  end

  // Channel 1 counter and ramp
  ldc_chan chan1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .dimTick(dimTick_reg),
    .ssTick(ssTick_reg[0]),
    .phaseOffset(10'h000),
    .counterSync(sync_reg),
    .dutyHighIn(dimDutyHighPart1),
    .dutyHighWr(dimDutyHighWr1),
    .dutyLowIn(dimDutyLowPart1),
    .dutyLowWr(dimDutyLowWr1),
    .channelOn(chanOn[0]),
    .dimActive(srcDim[0]),
    .dimOut(chanDim[0]),
    .dimCount(cnt1),
    .rampValue(ramp1),
    .rampDone(chanRampDone[0])
  );

  // Channel 2 counter and ramp
  ldc_chan chan2 (
    .ref_clk(ref_clk),
    .rst(rst),
    .dimTick(dimTick_reg),
    .ssTick(ssTick_reg[1]),
    .phaseOffset(ch2Offset),
    .counterSync(sync_reg),
    .dutyHighIn(dimDutyHighPart2),
    .dutyHighWr(dimDutyHighWr2),
    .dutyLowIn(dimDutyLowPart2),
    .dutyLowWr(dimDutyLowWr2),
    .channelOn(chanOn[1]),
    .dimActive(srcDim[1]),
    .dimOut(chanDim[1]),
    .dimCount(cnt2),
    .rampValue(ramp2),
    .rampDone(chanRampDone[1])
  );

  // External pin sampled once; switching source may cost one period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extDim_reg <= 2'b00;
      prevDim_reg <= 2'b00;
    end else begin
      extDim_reg <= dimmingInputPin;
      prevDim_reg <= runDim;
    end
  end

  // Compensation reconnect waits for sense above comp after rising edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compArm_reg <= 2'b00;
      comp_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!runDim[i]) begin
          compArm_reg[i] <= 1'b0;
          comp_reg[i] <= 1'b0;
        end else if (dimRise[i]) begin
          compArm_reg[i] <= 1'b1;
        end else if (compArm_reg[i] && senseAboveComp[i]) begin
          compArm_reg[i] <= 1'b0;
          comp_reg[i] <= 1'b1;
        end
      end
      if (dualPhaseSelect) begin
        comp_reg[1] <= comp_reg[0];
      end
    end
  end

  // Registered drive outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      intDim_reg <= 2'b00;
      activeDim_reg <= 2'b00;
      gate_reg <= 2'b00;
      fet_reg <= 2'b00;
      swClkOut_reg <= 2'b00;
    end else begin
      intDim_reg <= intSel;
      activeDim_reg <= srcDim;
      gate_reg <= runDim;
      fet_reg <= runDim & seriesFetDriveEnable;
      swClkOut_reg <= swClk_reg;
    end
  end

  // Ramp converter codes and trim offsets
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ramp1_reg <= ldc_pkg::RAMP_RST;
      ramp2_reg <= ldc_pkg::RAMP_RST;
      trim1_reg <= 16'h0000;
      trim2_reg <= 16'h0000;
    end else begin
      ramp1_reg <= ramp1;
      ramp2_reg <= ch2Ramp ? ramp2Sel : ramp2Sel;
      trim1_reg <= 16'(phaseOffsetTrim1 * ldc_pkg::TRIM_STEP_CODE);
      trim2_reg <= 16'(phaseOffsetTrim2 * ldc_pkg::TRIM_STEP_CODE);
    end
  end

  // Mode flags; ch2 faults masked in dual phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ch2ErrorAmpDisable <= 1'b0;
      compTie <= 1'b0;
      ch2FaultsActive <= 1'b0;
    end else begin
      ch2ErrorAmpDisable <= dualPhaseSelect;
      compTie <= dualPhaseSelect;
      ch2FaultsActive <= |ch2FaultEvents && !dualPhaseSelect;
    end
  end

  assign internalDimSignal = intDim_reg;
  assign activeDim = activeDim_reg;
  assign switchGateEnable = gate_reg;
  assign seriesFetDrive = fet_reg;
  assign compensationConnect = comp_reg;
  assign channelSwitchClock = swClkOut_reg;
  assign rampConverter1 = ramp1_reg;
  assign rampConverter2 = ramp2_reg;
  assign trimOffsetUv1 = trim1_reg;
  assign trimOffsetUv2 = trim2_reg;
endmodule

// *** test/ldc_properties.sv ***
// Port-level assertions for the dimming and soft-start block
`timescale 1ns/1ns
module ldc_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched inputs
  input wire logic internalDimSelect,
  input wire logic dualPhaseSelect,
  input wire logic [1:0] channelEnable,
  input wire logic [1:0] seriesFetDriveEnable,
  input wire logic [1:0] channelGateOff,
  input wire logic [1:0] dimmingInputPin,
  input wire logic [1:0] senseAboveComp,
  input wire logic [2:0] phaseOffsetTrim1,
  // Watched outputs
  input wire logic [1:0] activeDim,
  input wire logic [1:0] switchGateEnable,
  input wire logic [1:0] seriesFetDrive,
  input wire logic [1:0] compensationConnect,
  input wire logic ch2ErrorAmpDisable,
  input wire logic compTie,
  input wire logic ch2FaultsActive,
  input wire logic [7:0] rampConverter1,
  input wire logic [15:0] trimOffsetUv1
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff rst;

  // Channel held off long enough for the output registers to drain
  sequence s_chan_off;
    (!channelEnable[0])[*3];
  endsequence
  sequence s_dim_low_on;
    (channelEnable[0] && !channelGateOff[0] && !activeDim[0])[*4];
  endsequence

  // Windows of three or four samples cover the two-cycle output latency
  chk_fet_gated: assert property (
    (!seriesFetDriveEnable[0])[*3] |-> !seriesFetDrive[0]) else $error("fet on while disabled");
  chk_pin_low_off: assert property ((!internalDimSelect && !dimmingInputPin[0])[*4]
    |-> !switchGateEnable[0]) else $error("gate on with pin low");
  chk_dim_low_off: assert property ((!activeDim[0])[*3]
    |-> !(switchGateEnable[0] || seriesFetDrive[0] || compensationConnect[0]))
    else $error("channel active while dim low");
  chk_comp_waits: assert property ($rose(compensationConnect[0])
    |-> $past(senseAboveComp[0]) || $past(senseAboveComp[0], 2))
    else $error("comp joined before sense");
  chk_gate_off: assert property (
    channelGateOff[0][*3] |-> !switchGateEnable[0]) else $error("gate on while forced off");
  chk_ramp_step: assert property (rampConverter1 != $past(rampConverter1)
    |-> rampConverter1 == $past(rampConverter1) + 8'h01 || rampConverter1 == 8'h00)
    else $error("ramp jumped");
  chk_ramp_clear: assert property (
    s_chan_off |-> rampConverter1 == 8'h00) else $error("ramp not cleared");
  chk_ramp_hold: assert property (
    s_dim_low_on |=> $stable(rampConverter1)) else $error("ramp moved while dim low");
  chk_trim_scale: assert property ($stable(phaseOffsetTrim1)[*4]
    |-> trimOffsetUv1 == 16'(phaseOffsetTrim1) * ldc_pkg::TRIM_STEP_CODE)
    else $error("trim offset wrong");
  chk_dual_tie: assert property (dualPhaseSelect[*3]
    |-> compTie && ch2ErrorAmpDisable && !ch2FaultsActive)
    else $error("dual phase sharing wrong");
endmodule

bind led_dimming_softstart_ctrl ldc_props u_props (.ref_clk, .rst, .internalDimSelect,
  .dualPhaseSelect, .channelEnable, .seriesFetDriveEnable, .channelGateOff, .dimmingInputPin,
  .senseAboveComp, .phaseOffsetTrim1, .activeDim, .switchGateEnable, .seriesFetDrive,
  .compensationConnect, .ch2ErrorAmpDisable, .compTie, .ch2FaultsActive, .rampConverter1,
  .trimOffsetUv1);

// *** test/ldc_dim_source.sv ***
// External dimming square-wave source for both pins
`timescale 1ns/1ns
module ldc_dim_source #(parameter int HALF = 40) (
  // Clock
  input wire logic ref_clk,
  // Control
  input wire logic run,
  // Pin levels
  output logic [1:0] pin
);
  int cnt = 0;
  // Free count; the wave only shows on the pins while running
  always @(posedge ref_clk) begin
    cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
  end
  // Idle pins rest at the pull-down level, never at a stale high
  assign pin = (run && cnt < HALF) ? 2'h3 : 2'h0;
endmodule

// *** test/tb.sv ***
// Self-checking testbench for the dimming and soft-start block
`timescale 1ns/1ns
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic intSel = 0, phSel = 0, dualSel = 0, srcRun = 0, hw = 0, lw = 0;
  logic [2:0] dimDiv = 0, trim1 = 0, trim2 = 0;
  logic [7:0] ss1 = 0, ss2 = 0, sw1 = 0, sw2 = 0, lo = 0;
  logic [1:0] chEn = 3, fetEn = 3, gOff = 0, hi = 0, sense = 0, faults = 0, pin;
  logic [1:0] intDim, actDim, gate, fet, comp, swClk;
  logic ampOff, tie, ch2Act;
  logic [7:0] ramp1, ramp2;
  logic [15:0] uv1, uv2;
  int failures = 0, n_tests = 0, n1, na, nb;

  always #25 ref_clk = ~ref_clk;

  ldc_dim_source src (.ref_clk(ref_clk), .run(srcRun), .pin(pin));
  led_dimming_softstart_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .internalDimSelect(intSel),
    .dimPhaseSelect(phSel), .dualPhaseSelect(dualSel), .dimClockDivider(dimDiv),
    .rampClockDivider1(ss1), .rampClockDivider2(ss2), .switchClockDivider1(sw1),
    .switchClockDivider2(sw2), .channelEnable(chEn), .seriesFetDriveEnable(fetEn),
    .channelGateOff(gOff), .phaseOffsetTrim1(trim1), .phaseOffsetTrim2(trim2),
    .dimDutyHighPart1(hi), .dimDutyHighWr1(hw), .dimDutyLowPart1(lo), .dimDutyLowWr1(lw),
    .dimDutyHighPart2(hi), .dimDutyHighWr2(hw), .dimDutyLowPart2(lo), .dimDutyLowWr2(lw),
    .dimmingInputPin(pin), .senseAboveComp(sense), .ch2FaultEvents(faults),
    .internalDimSignal(intDim), .activeDim(actDim), .switchGateEnable(gate),
    .seriesFetDrive(fet), .compensationConnect(comp), .ch2ErrorAmpDisable(ampOff),
    .compTie(tie), .channelSwitchClock(swClk), .rampConverter1(ramp1),
    .rampConverter2(ramp2), .trimOffsetUv1(uv1), .trimOffsetUv2(uv2),
    .ch2FaultsActive(ch2Act));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Duty write to both channels: high part, then low part on the next cycle
  task automatic duty(input logic [1:0] h, input logic [7:0] l);
    hi = h;
    hw = 1'b1;
    cyc(1);
    hw = 1'b0;
    lo = l;
    lw = 1'b1;
    cyc(1);
    lw = 1'b0;
  endtask

  // Bounded wait for a given level on pin 1
  task automatic wait_pin(input logic v);
    for (int i = 0; i < 200 && pin[0] !== v; i++) cyc(1);
    cyc(3);
  endtask

  // High-time counts of channel 1 and of both channels together
  task automatic measure(input int len);
    n1 = 0;
    na = 0;
    nb = 0;
    repeat (len) begin
      cyc(1);
      n1 += int'(intDim[0] === 1'b1);
      na += int'(actDim[0] === 1'b1);
      nb += int'(intDim === 2'h3);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 22k cycles of tests
  initial begin
    #(50 * 80000);
    failures++;
    report_and_stop;
  end

  initial begin
    cyc(16);
    rst = 1'b0;
    // Idle source pins held low after reset keep both channels dark and the ramp parked
    cyc(300);
    chk(gate, 2'h0);
    chk(ramp1, 8'h00);
    $display("reset test done");
    srcRun = 1'b1;
    wait_pin(1'b1);
    chk(gate, 2'h3);
    chk(fet, 2'h3);
    chk(comp, 2'h0);
    sense = 2'h3;
    fetEn = 2'h0;
    cyc(3);
    chk(comp, 2'h3);
    chk({gate, fet}, 4'hC);
    fetEn = 2'h3;
    wait_pin(1'b0);
    chk({gate, fet, comp}, 6'h00);
    wait_pin(1'b1);
    gOff = 2'h1;
    cyc(3);
    chk(gate, 2'h2);
    gOff = 2'h0;
    cyc(2000);
    chk({ramp1, ramp2}, 16'hFFFF);
    chEn = 2'h0;
    cyc(3);
    chk(ramp1, 8'h00);
    chEn = 2'h3;
    $display("external dimming test done");
    // Internal counter with the pins still toggling
    intSel = 1'b1;
    duty(2'h1, 8'h00);
    cyc(2100);
    measure(1024);
    chk(16'(n1), 16'd256);
    chk(16'(na), 16'd256);
    hi = 2'h3;
    hw = 1'b1;
    cyc(1);
    hw = 1'b0;
    cyc(2100);
    measure(1024);
    chk(16'(n1), 16'd256);
    duty(2'h2, 8'h00);
    cyc(2100);
    measure(1024);
    chk(16'(n1), 16'd512);
    chk(16'(nb), 16'd0);
    phSel = 1'b1;
    cyc(2100);
    measure(1024);
    chk(16'(nb), 16'd512);
    dimDiv = 3'h1;
    cyc(4200);
    measure(2048);
    chk(16'(n1), 16'd1024);
    $display("internal dimming test done");
    // Two-phase: channel 2 settings must have no say
    dualSel = 1'b1;
    faults = 2'h3;
    sw1 = 8'h03;
    sw2 = 8'h07;
    ss2 = 8'hFF;
    chEn = 2'h0;
    cyc(4);
    chk({tie, ampOff, ch2Act}, 3'h6);
    chEn = 2'h3;
    cyc(200);
    chk(ramp2, ramp1);
    n1 = 0;
    na = 0;
    nb = 0;
    repeat (400) begin
      cyc(1);
      n1 += int'(swClk[0] === 1'b1);
      na += int'(swClk[1] === 1'b1);
      nb += int'(swClk === 2'h3);
    end
    chk(16'(na), 16'(n1));
    chk({16'(n1), 16'(nb)}, {16'd100, 16'd0});
    $display("dual phase test done");
    for (int c = 0; c < 8; c++) begin
      trim1 = 3'(c);
      trim2 = 3'(7 - c);
      cyc(4);
      chk(uv1, 16'(c * 2500));
      chk(uv2, 16'((7 - c) * 2500));
    end
    $display("trim test done");
    // Leaving two-phase mode lets channel 2 faults count again
    dualSel = 1'b0;
    cyc(3);
    chk({tie, ampOff, ch2Act}, 3'h1);
    report_and_stop;
  end
endmodule
